/* File: rtl/zone1_ext_cfg.svh */
// Purpose: Constants for the Zone 1 reach extension control block.
// Assumes: Word-indexed register port; times in hundredths of a cycle.
// Notes:   Definitions only.
`ifndef ZONE1_EXT_CFG_SVH
`define ZONE1_EXT_CFG_SVH
`define CORE_CLK_HZ      50000000
`define NOM_FREQ_HZ      60
`define CYCLE_FRAC       100
`define ADDR_W           3
`define DATA_W           32
`define REG_MODE         3'h0
`define REG_DELAY        3'h1
`define REG_PMULT        3'h2
`define REG_GMULT        3'h3
`define REG_EXTSRC       3'h4
`define REG_STATUS       3'h5
`define MODE_LSB         0
`define MODE_MSB         1
`define PH_EN_BIT        2
`define GND_EN_BIT       3
`define DELAY_W          21
`define DELAY_MAX        21'h186A00
`define DELAY_RST        21'h000000
`define MULT_W           9
`define MULT_MIN         9'h064
`define MULT_MAX         9'h190
`define MULT_RST         9'h064
`define MULT_SCALE       100
`define Z2_NUM           11
`define Z2_DEN           1000
`define ST_PH_BIT        0
`define ST_GND_BIT       1
`define ST_COMB_BIT      2
`define ST_TMR_BIT       3
`define ST_REJ_BIT       4
`endif

/* File: rtl/zone1_ext_pkg.sv */
// Purpose: Types shared by the Zone 1 reach extension control block.
// Assumes: Nothing beyond the configuration header.
// Notes:   Mode codes follow a Gray path off, combined, independent.
package zone1_ext_pkg;
  typedef enum logic [1:0] {
    MODE_OFF      = 2'h0,
    MODE_COMBINED = 2'h1,
    MODE_INDEP    = 2'h3
  } ext_mode_t;
endpackage : zone1_ext_pkg

/* File: rtl/zone1_reach_extension_control.sv */
// Purpose: Independent phase and ground Zone 1 reach extension control.
// Assumes: All inputs synchronous to core_clk; reaches are unsigned.
// Notes:   Multipliers are held in hundredths, delay in 1/100 cycle.
//
// Chosen here: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "zone1_ext_cfg.svh"
module zone1_reach_extension_control #(
  parameter int REACH_W  = 16,
  parameter int TICK_DIV = `CORE_CLK_HZ / (`NOM_FREQ_HZ * `CYCLE_FRAC)
) (
  input  wire logic                  core_clk,
  input  wire logic                  nrst,
  input  wire logic [`ADDR_W-1:0]    addr,
  input  wire logic [`DATA_W-1:0]    wdata,
  input  wire logic                  wr_stb,
  input  wire logic                  rd_stb,
  output      logic [`DATA_W-1:0]    rdata,
  input  wire logic                  group_change,
  input  wire logic                  breaker_closed,
  input  wire logic                  three_pole_open,
  input  wire logic                  phase_zone1_pickup,
  input  wire logic                  phase_zone2_pickup,
  input  wire logic                  ground_zone1_pickup,
  input  wire logic                  ground_zone2_pickup,
  input  wire logic                  residual_overcurrent_time_pickup,
  input  wire logic                  negseq_overcurrent_time_pickup,
  input  wire logic                  phase_ext_external_ctrl,
  input  wire logic                  ground_ext_external_ctrl,
  input  wire logic                  phase_elem_en,
  input  wire logic                  mho_ground_elem_en,
  input  wire logic                  quad_ground_elem_en,
  input  wire logic [REACH_W-1:0]    phase_zone1_reach,
  input  wire logic [REACH_W-1:0]    mho_ground_zone1_reach,
  input  wire logic [REACH_W-1:0]    quad_ground_zone1_reactance,
  input  wire logic [REACH_W-1:0]    phase_zone2_reach,
  input  wire logic [REACH_W-1:0]    mho_ground_zone2_reach,
  input  wire logic [REACH_W-1:0]    quad_ground_zone2_reactance,
  output      logic                  phase_ext_active,
  output      logic                  ground_ext_active,
  output      logic                  combined_ext_active,
  output      logic [REACH_W+1:0]    phase_zone1_eff_reach,
  output      logic [REACH_W+1:0]    mho_ground_zone1_eff_reach,
  output      logic [REACH_W+1:0]    quad_ground_zone1_eff_reactance
);
  import zone1_ext_pkg::*;

  // A reach times a multiplier in hundredths needs the reach width
  // plus the multiplier width before the division by one hundred.
  localparam int PROD_W = REACH_W + `MULT_W;

  // Refuse parameter values the divider or scaling cannot serve.
  if (TICK_DIV < 2 || TICK_DIV > 65535) begin : g_bad_div
    $error("TICK_DIV must lie between 2 and 65535");
  end
  if (REACH_W < 4 || REACH_W > 20) begin : g_bad_reach
    $error("REACH_W must lie between 4 and 20");
  end

  // Zone 2 must be set and exceed 110 percent of extended zone 1.
  function automatic logic reach_ok(input logic               en,
                                    input logic [REACH_W-1:0] z1,
                                    input logic [REACH_W-1:0] z2,
                                    input logic [`MULT_W-1:0] m);
    logic [47:0] lhs;
    logic [47:0] rhs;
    lhs = 48'(z2) * 48'(`Z2_DEN);
    rhs = 48'(z1) * 48'(`Z2_NUM) * 48'(m);
    reach_ok = !en || (z1 != '0 && z2 != '0 && lhs > rhs);
  endfunction : reach_ok

  // Scales a reach by a multiplier held in hundredths.
  function automatic logic [REACH_W+1:0] scale(
      input logic [REACH_W-1:0] r, input logic [`MULT_W-1:0] m);
    logic [PROD_W-1:0] p;
    p = PROD_W'(r) * PROD_W'(m);
    scale = (REACH_W+2)'(p / PROD_W'(`MULT_SCALE));
  endfunction : scale

  ext_mode_t              mode;
  logic                   ph_en;
  logic                   gnd_en;
  logic [`DELAY_W-1:0]    delay;
  logic [`MULT_W-1:0]     pmult;
  logic [`MULT_W-1:0]     gmult;
  logic                   src_ph;
  logic                   src_gnd;
  logic                   rejected;
  logic                   settings_chg;
  logic [15:0]            div_cnt;
  logic                   tick;
  logic [`DELAY_W-1:0]    tmr_cnt;
  logic                   tmr_done;

  // Write decode and candidate settings for validation.
  wire wr_mode  = wr_stb && addr == `REG_MODE;
  wire wr_delay = wr_stb && addr == `REG_DELAY;
  wire wr_pmult = wr_stb && addr == `REG_PMULT;
  wire wr_gmult = wr_stb && addr == `REG_GMULT;
  wire wr_src   = wr_stb && addr == `REG_EXTSRC;
  wire [1:0] w_mode = wdata[`MODE_MSB:`MODE_LSB];
  wire [1:0] cand_mode = wr_mode ? w_mode : mode;
  wire [`MULT_W-1:0] w_mult = wdata[`MULT_W-1:0];
  wire [`MULT_W-1:0] cand_pm = wr_pmult ? w_mult : pmult;
  wire [`MULT_W-1:0] cand_gm = wr_gmult ? w_mult : gmult;
  wire mult_range = wdata[`DATA_W-1:`MULT_W] == '0 &&
                    w_mult >= `MULT_MIN && w_mult <= `MULT_MAX;
  wire delay_range = wdata[`DATA_W-1:`DELAY_W] == '0 &&
                     wdata[`DELAY_W-1:0] <= `DELAY_MAX;
  wire mode_legal = w_mode == MODE_OFF || w_mode == MODE_COMBINED ||
                    w_mode == MODE_INDEP;
  wire mode_on  = mode != MODE_OFF;
  wire indep    = mode == MODE_INDEP;
  wire delay_vis = indep && (ph_en || gnd_en);

  // Extended reaches must still sit inside zone 2.
  // The live reach inputs are judged in the cycle of the strobe only,
  // so a later change of the reaches is not checked again.
  wire reaches_ok = cand_mode == MODE_OFF ||
      (reach_ok(phase_elem_en, phase_zone1_reach, phase_zone2_reach,
                cand_pm) &&
       reach_ok(mho_ground_elem_en, mho_ground_zone1_reach,
                mho_ground_zone2_reach, cand_gm) &&
       reach_ok(quad_ground_elem_en, quad_ground_zone1_reactance,
                quad_ground_zone2_reactance, cand_gm));

  // Writes to hidden settings or out-of-range values are refused.
  wire acc_mode  = wr_mode && mode_legal && reaches_ok;
  wire acc_delay = wr_delay && delay_vis && delay_range;
  wire acc_pmult = wr_pmult && mode_on && mult_range &&
                   reaches_ok;
  wire acc_gmult = wr_gmult && mode_on && mult_range &&
                   reaches_ok;
  wire accepted  = acc_mode || acc_delay || acc_pmult || acc_gmult ||
                   wr_src;
  wire refused   = wr_stb && !accepted && addr <= `REG_EXTSRC;

  // Settings registers.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mode   <= MODE_OFF;
      ph_en  <= 1'b0;
      gnd_en <= 1'b0;
      delay  <= `DELAY_RST;
      pmult  <= `MULT_RST;
      gmult  <= `MULT_RST;
    end else begin
      if (acc_mode) begin
        mode   <= ext_mode_t'(w_mode);
        ph_en  <= wdata[`PH_EN_BIT];
        gnd_en <= wdata[`GND_EN_BIT];
      end
      if (acc_delay) begin
        delay <= wdata[`DELAY_W-1:0];
      end
      if (acc_pmult) begin
        pmult <= w_mult;
      end
      if (acc_gmult) begin
        gmult <= w_mult;
      end
    end
  end

  // External control sources start as constant zero.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      src_ph  <= 1'b0;
      src_gnd <= 1'b0;
    end else if (wr_src) begin
      src_ph  <= wdata[0];
      src_gnd <= wdata[1];
    end
  end

  // Last-write verdict and the settings-change pulse.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rejected     <= 1'b0;
      settings_chg <= 1'b0;
    end else begin
      if (accepted || refused) begin
        rejected <= refused;
      end
      settings_chg <= accepted || group_change;
    end
  end

  // Divider giving one pulse per hundredth of a power cycle.
  // The default ratio suits a 60 Hz system; other system frequencies
  // need TICK_DIV set to match, or the delay runs fast or slow.
  assign tick = div_cnt == 16'(TICK_DIV - 1);
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      div_cnt <= 16'h0000;
    end else if (tick) begin
      div_cnt <= 16'h0000;
    end else begin
      div_cnt <= div_cnt + 16'h0001;
    end
  end

  // Breaker-closed delay timer; a settings or group change clears the
  // pending wait so a closed breaker qualifies at once.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tmr_cnt  <= `DELAY_RST;
      tmr_done <= 1'b0;
    end else if (!breaker_closed) begin
      tmr_cnt  <= `DELAY_RST;
      tmr_done <= 1'b0;
    end else if (settings_chg) begin
      tmr_cnt  <= `DELAY_RST;
      tmr_done <= 1'b1;
    end else if (tick && !tmr_done) begin
      if (tmr_cnt >= delay) begin
        tmr_done <= 1'b1;
      end else begin
        tmr_cnt <= tmr_cnt + `DELAY_W'(1);
      end
    end
  end

  // Any zone or time-overcurrent pickup blocks internal extension.
  wire pickup_block = phase_zone1_pickup || phase_zone2_pickup ||
                      ground_zone1_pickup || ground_zone2_pickup ||
                      residual_overcurrent_time_pickup ||
                      negseq_overcurrent_time_pickup;
  wire int_ok  = breaker_closed && tmr_done && !three_pole_open &&
                 !pickup_block;
  wire int_ph  = indep && ph_en && int_ok;
  wire int_gnd = indep && gnd_en && int_ok;

  // External path is not supervised by pole state or pickups.
  wire ext_ph  = indep && src_ph && phase_ext_external_ctrl;
  wire ext_gnd = indep && src_gnd && ground_ext_external_ctrl;

  // Active bits; outside independent mode both stay low.
  wire next_phase  = ext_ph || int_ph;
  wire next_ground = ext_gnd || int_gnd;
  wire next_comb   = int_ph || int_gnd;

  // Effective reaches follow the registered active bits.
  wire [REACH_W+1:0] base_ph   = (REACH_W+2)'(phase_zone1_reach);
  wire [REACH_W+1:0] base_mho  = (REACH_W+2)'(mho_ground_zone1_reach);
  wire [REACH_W+1:0] base_quad = (REACH_W+2)'(quad_ground_zone1_reactance);
  wire [REACH_W+1:0] next_ph_reach = phase_ext_active ?
      scale(phase_zone1_reach, pmult) : base_ph;
  wire [REACH_W+1:0] next_mho_reach = ground_ext_active ?
      scale(mho_ground_zone1_reach, gmult) : base_mho;
  wire [REACH_W+1:0] next_quad_reach = ground_ext_active ?
      scale(quad_ground_zone1_reactance, gmult) : base_quad;

  // Output registers.
  // Reaches lag the active bits by one clock, so a reach is never
  // scaled by an active bit that the block has not yet shown.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      phase_ext_active                <= 1'b0;
      ground_ext_active               <= 1'b0;
      combined_ext_active             <= 1'b0;
      phase_zone1_eff_reach           <= '0;
      mho_ground_zone1_eff_reach      <= '0;
      quad_ground_zone1_eff_reactance <= '0;
    end else begin
      phase_ext_active                <= next_phase;
      ground_ext_active               <= next_ground;
      combined_ext_active             <= next_comb;
      phase_zone1_eff_reach           <= next_ph_reach;
      mho_ground_zone1_eff_reach      <= next_mho_reach;
      quad_ground_zone1_eff_reactance <= next_quad_reach;
    end
  end

  // Read selection; hidden settings read as zero.
  logic [`DATA_W-1:0] next_rdata;
  always_comb begin
    next_rdata = '0;
    unique case (addr)
      `REG_MODE: begin
        next_rdata[`MODE_MSB:`MODE_LSB] = mode;
        next_rdata[`PH_EN_BIT]  = indep && ph_en;
        next_rdata[`GND_EN_BIT] = indep && gnd_en;
      end
      `REG_DELAY: begin
        next_rdata[`DELAY_W-1:0] = delay_vis ? delay : '0;
      end
      `REG_PMULT: begin
        next_rdata[`MULT_W-1:0] = mode_on ? pmult : '0;
      end
      `REG_GMULT: begin
        next_rdata[`MULT_W-1:0] = mode_on ? gmult : '0;
      end
      `REG_EXTSRC: begin
        next_rdata[1:0] = {src_gnd, src_ph};
      end
      `REG_STATUS: begin
        next_rdata[`ST_PH_BIT]   = phase_ext_active;
        next_rdata[`ST_GND_BIT]  = ground_ext_active;
        next_rdata[`ST_COMB_BIT] = combined_ext_active;
        next_rdata[`ST_TMR_BIT]  = tmr_done;
        next_rdata[`ST_REJ_BIT]  = rejected;
      end
      default: begin
        next_rdata = '0;
      end
    endcase
  end

  // Read data stands only in the cycle after the read strobe.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= '0;
    end else begin
      rdata <= rd_stb ? next_rdata : '0;
    end
  end

endmodule : zone1_reach_extension_control

/* File: verification/zone1_ext_monitor.sv */
// Purpose: Port-level checks for the Zone 1 reach extension control.
// Assumes: One clock domain; reset asynchronous and active low.
// Notes:   Bound into the control block by the statement at the foot.
`timescale 1ns/1ps
module zone1_ext_monitor #(
  parameter int REACH_W = 16
) (
  input wire logic               core_clk,
  input wire logic               nrst,
  input wire logic               breaker_closed,
  input wire logic               three_pole_open,
  input wire logic               phase_zone1_pickup,
  input wire logic               phase_zone2_pickup,
  input wire logic               ground_zone1_pickup,
  input wire logic               ground_zone2_pickup,
  input wire logic               residual_overcurrent_time_pickup,
  input wire logic               negseq_overcurrent_time_pickup,
  input wire logic               phase_ext_external_ctrl,
  input wire logic               ground_ext_external_ctrl,
  input wire logic [REACH_W-1:0] phase_zone1_reach,
  input wire logic [REACH_W-1:0] mho_ground_zone1_reach,
  input wire logic               phase_ext_active,
  input wire logic               ground_ext_active,
  input wire logic               combined_ext_active,
  input wire logic [REACH_W+1:0] phase_zone1_eff_reach,
  input wire logic [REACH_W+1:0] mho_ground_zone1_eff_reach
);
  // Any one of the six pickups blocks the internal paths.
  wire any_pickup = phase_zone1_pickup | phase_zone2_pickup |
    ground_zone1_pickup | ground_zone2_pickup |
    residual_overcurrent_time_pickup | negseq_overcurrent_time_pickup;

  // Active bits follow their causes one edge later, reaches one more.
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  a_phase_unscaled: assert property (!phase_ext_active |=>
    phase_zone1_eff_reach == $past(phase_zone1_reach))
    else $error("phase reach scaled while inactive");
  a_phase_scaled_range: assert property (phase_ext_active |=>
    phase_zone1_eff_reach >= $past(phase_zone1_reach) &&
    phase_zone1_eff_reach <= 4 * $past(phase_zone1_reach))
    else $error("phase reach outside one to four times");
  a_ground_unscaled: assert property (!ground_ext_active |=>
    mho_ground_zone1_eff_reach == $past(mho_ground_zone1_reach))
    else $error("ground reach scaled while inactive");
  a_pole_open_drop: assert property (three_pole_open |=>
    !combined_ext_active)
    else $error("internal control active with pole open");
  a_breaker_open_drop: assert property (
    !breaker_closed && !phase_ext_external_ctrl |=> !phase_ext_active)
    else $error("phase active with breaker open");
  a_phase_pickup_block: assert property (
    any_pickup && !phase_ext_external_ctrl |=> !phase_ext_active)
    else $error("phase active during pickup");
  a_ground_pickup_block: assert property (
    any_pickup && !ground_ext_external_ctrl |=> !ground_ext_active)
    else $error("ground active during pickup");
  a_combined_subset: assert property (combined_ext_active |->
    phase_ext_active || ground_ext_active)
    else $error("combined bit without an active path");
  c_phase_on: cover property ($rose(phase_ext_active));
  c_ground_on: cover property ($rose(ground_ext_active));
  c_combined_on: cover property ($rose(combined_ext_active));
endmodule : zone1_ext_monitor

bind zone1_reach_extension_control zone1_ext_monitor
  #(.REACH_W(REACH_W)) zone1_ext_monitor_i (.*);

/* File: verification/zone1_far_model.sv */
// Purpose: Far-side model of breaker state, pickups and user equations.
// Assumes: The bench requests levels through far_cmd.
// Notes:   Levels change just after a clock edge, as relay logic does.
`timescale 1ns/1ps
module zone1_far_model (
  input  wire logic       core_clk,
  input  wire logic [8:0] far_cmd,
  output      logic       breaker_closed,
  output      logic       three_pole_open,
  output      logic [5:0] pickups,
  output      logic       phase_ext_external_ctrl,
  output      logic       ground_ext_external_ctrl
);
  // Equations start at logical zero with the breaker open.
  initial begin
    {phase_ext_external_ctrl, ground_ext_external_ctrl} = 2'h0;
    {breaker_closed, pickups} = 7'h00;
    three_pole_open = 1'b1;
  end

  // Pole-open status always mirrors the breaker.
  always @(posedge core_clk) begin
    breaker_closed <= far_cmd[0];
    three_pole_open <= !far_cmd[0];
    pickups <= far_cmd[6:1];
    phase_ext_external_ctrl <= far_cmd[7];
    ground_ext_external_ctrl <= far_cmd[8];
  end
endmodule : zone1_far_model

/* File: verification/tb_zone1_reach_extension_control.sv */
// Purpose: Self-checking bench for the Zone 1 reach extension control.
// Assumes: Tick divider of 2 to keep delays short.
// Notes:   Register reads are scored from a queue of expected words.
`timescale 1ns/1ps
`include "zone1_ext_cfg.svh"
module tb_zone1_reach_extension_control;
  import zone1_ext_pkg::*;
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
  $display("CHECK FAILED t=%0t got %0h exp %0h", $time, g, e); end end
  logic core_clk = 0, nrst = 0, wr_stb = 0, rd_stb = 0, rd_seen = 0;
  logic group_change = 0, phase_elem_en = 1, mho_ground_elem_en = 1;
  logic quad_ground_elem_en = 1, breaker_closed, three_pole_open;
  logic [2:0] addr = '0;
  logic [31:0] wdata = '0, rdata, ex, q[$];
  logic phase_ext_external_ctrl, ground_ext_external_ctrl;
  logic phase_ext_active, ground_ext_active, combined_ext_active;
  logic phase_zone1_pickup, phase_zone2_pickup, ground_zone1_pickup;
  logic ground_zone2_pickup, residual_overcurrent_time_pickup;
  logic negseq_overcurrent_time_pickup;
  logic [15:0] phase_zone1_reach, mho_ground_zone1_reach, seed = 16'h0029;
  logic [15:0] quad_ground_zone1_reactance, phase_zone2_reach;
  logic [15:0] mho_ground_zone2_reach, quad_ground_zone2_reactance;
  logic [17:0] phase_zone1_eff_reach, mho_ground_zone1_eff_reach;
  logic [17:0] quad_ground_zone1_eff_reactance;
  logic [5:0] pickups;
  logic [8:0] far_cmd = '0;
  int num_errors = 0, n_tests = 0, pm, gm, i, k;

  zone1_reach_extension_control #(.REACH_W(16), .TICK_DIV(2))
    zone1_reach_extension_control_i (.*);
  zone1_far_model zone1_far_model_i (.*);
  assign {negseq_overcurrent_time_pickup, residual_overcurrent_time_pickup,
    ground_zone2_pickup, ground_zone1_pickup, phase_zone2_pickup,
    phase_zone1_pickup} = pickups;

  // Free-running 50 MHz clock.
  always #10 core_clk = ~core_clk;

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  task automatic wr(input logic [2:0] a, input logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge core_clk);
    wr_stb <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a, input logic [31:0] e);
    @(posedge core_clk);
    addr <= a;
    rd_stb <= 1'b1;
    q.push_back(e);
    @(posedge core_clk);
    rd_stb <= 1'b0;
  endtask : rd

  task automatic far(input logic [8:0] v);
    @(posedge core_clk);
    far_cmd <= v;
  endtask : far

  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : wt

  task automatic final_report;
    $display("Compared %0d values, %0d mismatches", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : final_report

  // Read data stands in the cycle after the strobe; score it there.
  always @(posedge core_clk) rd_seen <= rd_stb;
  always @(negedge core_clk) begin
    if (rd_seen) begin
      ex = q.pop_front();
      `CHK(rdata, ex)
    end
  end

  initial begin
    seed = lfsr(seed);
    phase_zone1_reach = {6'h00, seed[9:0]} | 16'h0001;
    phase_zone2_reach = seed | 16'h8000;
    seed = lfsr(seed);
    mho_ground_zone1_reach = {6'h00, seed[9:0]} | 16'h0001;
    mho_ground_zone2_reach = seed | 16'h8000;
    seed = lfsr(seed);
    quad_ground_zone1_reactance = {6'h00, seed[9:0]} | 16'h0001;
    quad_ground_zone2_reactance = seed | 16'h8000;
    pm = 100 + int'(seed % 301);
    gm = 100 + int'(lfsr(seed) % 301);
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
    rd(0, 0);
    rd(1, 0);
    rd(2, 0);
    rd(3, 0);
    rd(4, 0);
    rd(6, 0);
    $display("test reset done");
    wr(4, 32'h3);
    far(9'h180);
    wr(2, 32'hC8);
    rd(2, 0);
    rd(5, 32'h10);
    wr(0, 32'h1);
    rd(2, 32'h64);
    rd(3, 32'h64);
    wt(4);
    `CHK({phase_ext_active, ground_ext_active}, 2'h0)
    wr(0, 32'h2);
    rd(0, 32'h1);
    $display("test off and combined done");
    wr(0, 32'(MODE_INDEP));
    wr(2, 32'(pm));
    wr(3, 32'(gm));
    wr(1, 32'h5);
    rd(1, 0);
    far(9'h1FE);
    wt(4);
    `CHK({phase_ext_active, ground_ext_active}, 2'h3)
    far(9'h080);
    wt(4);
    `CHK({phase_ext_active, ground_ext_active}, 2'h2)
    `CHK(combined_ext_active, 1'b0)
    ex = 32'((32'(phase_zone1_reach) * pm) / 100);
    `CHK(phase_zone1_eff_reach, ex[17:0])
    `CHK(mho_ground_zone1_eff_reach, 18'(mho_ground_zone1_reach))
    far(9'h100);
    wt(4);
    `CHK({phase_ext_active, ground_ext_active}, 2'h1)
    ex = 32'((32'(quad_ground_zone1_reactance) * gm) / 100);
    `CHK(quad_ground_zone1_eff_reactance, ex[17:0])
    wr(2, 32'd401);
    rd(2, 32'(pm));
    wr(3, 32'd99);
    rd(3, 32'(gm));
    wr(2, 32'd400);
    rd(2, 32'd400);
    $display("test external control done");
    wr(0, 32'(MODE_INDEP) | 32'hC);
    wr(1, 32'h186A01);
    far(9'h000);
    wr(1, 32'd6);
    rd(1, 32'd6);
    far(9'h001);
    wt(6);
    `CHK({phase_ext_active, ground_ext_active}, 2'h0)
    for (k = 0; k < 60 && phase_ext_active !== 1'b1; k++) wt(1);
    if (k == 60) begin
      num_errors++;
      $display("CHECK FAILED t=%0t extension never began", $time);
      final_report();
    end
    wt(1);
    `CHK({ground_ext_active, combined_ext_active}, 2'h3)
    for (i = 0; i < 6; i++) begin
      far(9'h001 | (9'h002 << i));
      wt(3);
      `CHK({phase_ext_active, ground_ext_active}, 2'h0)
    end
    far(9'h000);
    wt(3);
    `CHK({phase_ext_active, ground_ext_active}, 2'h0)
    rd(5, 0);
    far(9'h001);
    wt(1);
    @(posedge core_clk);
    group_change <= 1'b1;
    @(posedge core_clk);
    group_change <= 1'b0;
    wt(4);
    `CHK({phase_ext_active, ground_ext_active}, 2'h3)
    rd(5, 32'hF);
    $display("test internal control done");
    wt(3);
    final_report();
  end
endmodule : tb_zone1_reach_extension_control
